// *** shc_standby_ctrl.v ***
// standby halt controller: enters light, oscillator-only or stop halt on a
// halt pulse from the core and wakes on interrupts or reset
// assumes all inputs synchronous to clk_i and the core waits for cpu_run_o
`timescale 1ns/1ns
`include "shc_defs.vh"

// What this block does
// [RL1] light idle stops the core; only peripherals with run enables keep clocking
// [RL2] oscillator-only idle keeps oscillator running but stops the system clock
// [RL3] oscillator-only idle pin buffers follow drive-select and drive-enable bits
// [RL4] wake requests seen without system clock; exit and restart are clocked
// [RL5] stop state halts everything including the oscillator
// [RL6] stop state pin buffers follow the drive-enable bit only
// [RL7] stop release restarts oscillator; system clock held off through warm-up
// [RL8] warm-up select 01 gives 2^8, 10 gives 2^14, 11 gives 2^16 cycles
// [RL9] external interrupt zero wakes the oscillator-only idle state
// [RL10] halt mode 11 picks light idle, 01 picks stop
// [RL11] wake on level above mask, non-maskable, or masked external 0 to 3
// [RL12] reset leaves any halt; interrupt wake keeps all prior state
// [RL13] warm-up counted on oscillator, loaded at release, clock on at terminal count
// [RL14] core pulses halt once and resumes only once the clock runs again
module shc_standby_ctrl #(
   parameter N_PERIPH = 9,
   parameter WUP_CYC0 = `SHC_WUP_CYC0,
   parameter WUP_CYC1 = `SHC_WUP_CYC1,
   parameter WUP_CYC2 = `SHC_WUP_CYC2,
   parameter WUP_CYC3 = `SHC_WUP_CYC3
) (
   input wire clk_i, // oscillator-derived clock
   input wire nrst_i, // synchronous reset, active low
   input wire halt_req_i, // one-cycle pulse: halt instruction done
   input wire [1:0] halt_mode_field_i, // halt mode select
   input wire [1:0] warmup_select_field_i, // warm-up length select
   input wire drive_sel_i, // pin drive-select bit
   input wire drive_en_i, // pin drive-enable bit
   input wire [N_PERIPH-1:0] idle_run_en_i, // per-peripheral light idle run
   input wire int_req_i, // maskable interrupt pending
   input wire [2:0] int_level_i, // level of pending interrupt
   input wire [2:0] interrupt_mask_level_i, // current core mask
   input wire nmi_i, // non-maskable request
   input wire [3:0] ext_int_i, // external interrupts 0..3, bit 0 is zero
   output reg cpu_run_o, // core may execute
   output reg sysclk_en_o, // system clock gate enable
   output reg osc_en_o, // oscillator enable
   output reg [N_PERIPH-1:0] periph_clk_en_o, // per-peripheral clock enable
   output reg pin_hold_o, // pins keep pre-halt state
   output reg pin_cond_a_o, // pin buffers in condition A
   output reg pin_cond_b_o, // pin buffers in condition B
   output reg warmup_busy_o, // warm-up in progress
   output reg wake_o, // one-cycle pulse: core restarts
   output reg wake_take_int_o, // with wake_o: service the interrupt
   output reg [2:0] state_o // controller state
);

   localparam ST_RUN = `SHC_ST_RUN;
   localparam ST_LIGHT = `SHC_ST_LIGHT;
   localparam ST_OSC = `SHC_ST_OSC;
   localparam ST_STOP = `SHC_ST_STOP;
   localparam ST_WARM = `SHC_ST_WARM;
   localparam [`SHC_WUP_W-1:0] CYC0 = WUP_CYC0;
   localparam [`SHC_WUP_W-1:0] CYC1 = WUP_CYC1;
   localparam [`SHC_WUP_W-1:0] CYC2 = WUP_CYC2;
   localparam [`SHC_WUP_W-1:0] CYC3 = WUP_CYC3;

   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [1:0] wup_sel_q;
   reg [1:0] wup_sel_d;
   reg take_int_q;
   reg take_int_d;
   reg wake_d;
   reg warm_load;
   reg [`SHC_WUP_W-1:0] warm_val;
   wire warm_done;
   wire above_mask;
   wire serviced;
   wire wake_any;
   wire drive_cond_a_osc;
   wire drive_cond_a_stop;

   // wake detection is pure combinational logic, no clock needed to see it
   assign above_mask = int_req_i && (int_level_i > interrupt_mask_level_i); // see [RL4]
   assign serviced = nmi_i || above_mask; // see [RL11]
   // masked external 0..3 still wake; the controller never clears their flags
   assign wake_any = serviced || (ext_int_i != 4'h0); // see [RL11] see [RL9]

   // pin condition decode: both drive bits for oscillator-only idle, drive-enable alone for stop
   assign drive_cond_a_osc = !drive_en_i && drive_sel_i; // see [RL3]
   assign drive_cond_a_stop = !drive_en_i; // see [RL6]

   // warm-up length select, latched at halt entry so it survives the halt
   always @* begin
      case (wup_sel_q) // see [RL8]
         `SHC_WUP_SEL1: warm_val = CYC1;
         `SHC_WUP_SEL2: warm_val = CYC2;
         `SHC_WUP_SEL3: warm_val = CYC3;
         default: warm_val = CYC0;
      endcase
   end

   // halt state machine; every exit is taken on a clock edge
   always @* begin
      state_d = state_q;
      wup_sel_d = wup_sel_q;
      take_int_d = take_int_q;
      wake_d = 1'b0;
      warm_load = 1'b0;
      case (state_q)
         ST_RUN: begin
            if (halt_req_i) begin // see [RL14]
               wup_sel_d = warmup_select_field_i;
               case (halt_mode_field_i) // see [RL10]
                  `SHC_HALT_STOP: state_d = ST_STOP;
                  `SHC_HALT_OSC: state_d = ST_OSC;
                  default: state_d = ST_LIGHT;
               endcase
            end
         end
         ST_LIGHT, ST_OSC: begin
            if (wake_any) begin // see [RL4]
               take_int_d = serviced;
               wake_d = 1'b1;
               state_d = ST_RUN;
            end
         end
         ST_STOP: begin
            if (wake_any) begin
               take_int_d = serviced;
               warm_load = 1'b1; // see [RL13]
               state_d = ST_WARM;
            end
         end
         ST_WARM: begin
            if (warm_done) begin // see [RL7]
               wake_d = 1'b1;
               state_d = ST_RUN;
            end
         end
         default: state_d = ST_RUN;
      endcase
   end

   // state registers; interrupt wake keeps everything, reset clears it
   always @(posedge clk_i) begin
      if (!nrst_i) begin // see [RL12]
         state_q <= ST_RUN;
         wup_sel_q <= `SHC_RST_WUP_SEL;
         take_int_q <= 1'b0;
      end else begin
         state_q <= state_d;
         wup_sel_q <= wup_sel_d;
         take_int_q <= take_int_d;
      end
   end

   // warm-up counter runs on the oscillator once it restarts
   shc_warmup_cnt #(
      .W(`SHC_WUP_W)
   ) u_warm (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .load_i(warm_load),
      .load_val_i(warm_val),
      .done_o(warm_done)
   );

   // registered outputs decoded from the next state so they line up with it
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         cpu_run_o <= 1'b1;
         sysclk_en_o <= 1'b1;
         osc_en_o <= 1'b1;
         periph_clk_en_o <= {N_PERIPH{1'b1}};
         pin_hold_o <= 1'b0;
         pin_cond_a_o <= 1'b0;
         pin_cond_b_o <= 1'b0;
         warmup_busy_o <= 1'b0;
         wake_o <= 1'b0;
         wake_take_int_o <= 1'b0;
         state_o <= ST_RUN;
      end else begin
         cpu_run_o <= (state_d == ST_RUN); // see [RL1]
         // clock stays gated through warm-up, only terminal count reopens it
         sysclk_en_o <= (state_d == ST_RUN); // see [RL2] see [RL7]
         osc_en_o <= (state_d != ST_STOP); // see [RL5]
         if (state_d == ST_RUN) begin
            periph_clk_en_o <= {N_PERIPH{1'b1}};
         end else if (state_d == ST_LIGHT) begin
            periph_clk_en_o <= idle_run_en_i; // see [RL1]
         end else begin
            periph_clk_en_o <= {N_PERIPH{1'b0}}; // see [RL2] see [RL5]
         end
         pin_hold_o <= (state_d == ST_LIGHT);
         if (state_d == ST_OSC) begin
            pin_cond_a_o <= drive_cond_a_osc; // see [RL3]
            pin_cond_b_o <= !drive_cond_a_osc;
         end else if (state_d == ST_STOP || state_d == ST_WARM) begin
            pin_cond_a_o <= drive_cond_a_stop; // see [RL6]
            pin_cond_b_o <= !drive_cond_a_stop;
         end else begin
            pin_cond_a_o <= 1'b0;
            pin_cond_b_o <= 1'b0;
         end
         warmup_busy_o <= (state_d == ST_WARM);
         wake_o <= wake_d;
         wake_take_int_o <= wake_d && take_int_d;
         state_o <= state_d;
      end
   end

endmodule // shc_standby_ctrl

// *** shc_defs.vh ***
// constants shared by the standby halt controller and its warm-up counter
// assumes a 100 MHz oscillator-derived clock; only definitions here
`ifndef SHC_DEFS_VH
`define SHC_DEFS_VH

// halt_mode_field codes sampled when the halt instruction completes
`define SHC_HALT_LIGHT 2'h3
`define SHC_HALT_OSC 2'h2
`define SHC_HALT_STOP 2'h1
`define SHC_HALT_RSVD 2'h0

// warmup_select_field codes
`define SHC_WUP_SEL0 2'h0
`define SHC_WUP_SEL1 2'h1
`define SHC_WUP_SEL2 2'h2
`define SHC_WUP_SEL3 2'h3

// warm-up lengths in oscillator cycles
`define SHC_WUP_CYC0 256
`define SHC_WUP_CYC1 256
`define SHC_WUP_CYC2 16384
`define SHC_WUP_CYC3 65536
`define SHC_WUP_W 17

// controller states
`define SHC_ST_RUN 3'h0
`define SHC_ST_LIGHT 3'h1
`define SHC_ST_OSC 3'h2
`define SHC_ST_STOP 3'h3
`define SHC_ST_WARM 3'h4

// reset values
`define SHC_RST_WUP_SEL 2'h0

`endif

// *** shc_warmup_cnt.v ***
// oscillator warm-up down-counter used after the deepest stop state
// assumes clk_i is the restarted oscillator and load_i a one-cycle pulse
`timescale 1ns/1ns

module shc_warmup_cnt #(
   parameter W = 17
) (
   input wire clk_i, // oscillator clock
   input wire nrst_i, // synchronous reset, active low
   input wire load_i, // load pulse on stop release
   input wire [W-1:0] load_val_i, // cycles to wait, at least 1
   output wire done_o // high on the last cycle of the interval
);

   reg [W-1:0] cnt_q;
   reg [W-1:0] cnt_d;

   // count down to one, then park at zero
   always @* begin
      cnt_d = cnt_q;
      if (load_i) begin
         cnt_d = load_val_i;
      end else if (cnt_q != {W{1'b0}}) begin
         cnt_d = cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge clk_i) begin
      if (!nrst_i) begin
         cnt_q <= {W{1'b0}};
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // terminal count only; a loaded value always passes through one
   assign done_o = (cnt_q == {{(W-1){1'b0}}, 1'b1});

endmodule // shc_warmup_cnt

// *** shc_props.sv ***
// assertion checker for the standby halt controller
// bound onto shc_standby_ctrl from tb; sees only its ports
`timescale 1ns/1ns
module shc_props #(
   parameter N_PERIPH = 9,
   parameter WUP_CYC0 = 256,
   parameter WUP_CYC1 = 256,
   parameter WUP_CYC2 = 16384,
   parameter WUP_CYC3 = 65536
) (
   input wire clk_i, // clock
   input wire nrst_i, // reset, active low
   input wire halt_req_i, // halt pulse
   input wire [1:0] halt_mode_field_i, // halt mode
   input wire [1:0] warmup_select_field_i, // warm-up select
   input wire drive_sel_i, // drive-select
   input wire drive_en_i, // drive-enable
   input wire [3:0] ext_int_i, // external requests
   input wire cpu_run_o, // core run
   input wire sysclk_en_o, // clock gate
   input wire osc_en_o, // oscillator
   input wire [N_PERIPH-1:0] periph_clk_en_o, // peripheral gates
   input wire pin_hold_o, // pins held
   input wire pin_cond_a_o, // condition a
   input wire pin_cond_b_o, // condition b
   input wire warmup_busy_o, // warming
   input wire wake_o, // wake pulse
   input wire [2:0] state_o // state
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   reg [1:0] sel_q;
   reg [16:0] cnt_q;
   wire [31:0] need_w = (sel_q == 2'h3) ? WUP_CYC3 : (sel_q == 2'h2) ? WUP_CYC2 : (sel_q == 2'h1) ? WUP_CYC1 : WUP_CYC0;
   // select latched at entry, since the bench may change it while warming
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         sel_q <= 2'h0;
         cnt_q <= 17'h0_0000;
      end else begin
         if (halt_req_i && state_o == 3'h0) sel_q <= warmup_select_field_i;
         cnt_q <= (state_o == 3'h4) ? cnt_q + 17'h0_0001 : 17'h0_0000;
      end
   end
   AST_LIGHT_CPU: assert property (state_o == 3'h1 |-> !cpu_run_o && pin_hold_o)
      else $error("light idle core runs");
   AST_OSC_CLK: assert property (state_o == 3'h2 |-> osc_en_o && !sysclk_en_o && periph_clk_en_o == 0)
      else $error("osc idle clocks wrong");
   AST_OSC_PINS: assert property (state_o == 3'h2 |-> pin_cond_a_o == (!drive_en_i && drive_sel_i) && pin_cond_b_o != pin_cond_a_o)
      else $error("osc idle pins wrong");
   AST_STOP_ALL: assert property (state_o == 3'h3 |-> !osc_en_o && !sysclk_en_o && !cpu_run_o)
      else $error("stop not halted");
   AST_STOP_PINS: assert property (state_o == 3'h3 |-> pin_cond_a_o == !drive_en_i && pin_cond_b_o == drive_en_i)
      else $error("stop pins wrong");
   AST_WARM_GATE: assert property (warmup_busy_o |-> osc_en_o && !sysclk_en_o && !cpu_run_o)
      else $error("clock during warm-up");
   AST_WARM_LEN: assert property (state_o == 3'h0 && $past(state_o) == 3'h4 |-> wake_o && cnt_q == need_w)
      else $error("warm-up length wrong");
   AST_MODE_STOP: assert property (state_o == 3'h0 && halt_req_i && halt_mode_field_i == 2'h1 |=> state_o == 3'h3)
      else $error("stop mode not entered");
   AST_OSC_WAKE: assert property (state_o == 3'h2 && ext_int_i[0] |=> wake_o && state_o == 3'h0 ##1 !wake_o)
      else $error("osc idle not woken");
endmodule // shc_props

// *** shc_core_model.sv ***
// core stand-in: turns a bench halt command into one halt pulse
// assumes halt_cmd_i is a level from the bench, synchronous to clk_i
`timescale 1ns/1ns
module shc_core_model (
   input wire clk_i, // clock
   input wire nrst_i, // reset, active low
   input wire halt_cmd_i, // bench wants a halt
   input wire cpu_run_i, // core may execute
   output reg halt_req_o // one-cycle halt pulse
);
   reg cmd_q;
   // a halted core executes nothing, so no pulse unless running
   always @(posedge clk_i) begin
      cmd_q <= nrst_i && halt_cmd_i;
      halt_req_o <= nrst_i && cpu_run_i && halt_cmd_i && !cmd_q;
   end
endmodule // shc_core_model

// *** tb.sv ***
// testbench for the standby halt controller
// core model issues halts; bench drives the wake lines directly
`timescale 1ns/1ns
module tb;
   reg clk_i, nrst_i, hcmd, int_req_i, nmi_i, drive_sel_i, drive_en_i;
   reg [1:0] halt_mode_field_i, warmup_select_field_i;
   reg [2:0] int_level_i, interrupt_mask_level_i;
   reg [3:0] ext_int_i;
   reg [8:0] idle_run_en_i;
   wire halt_req_i, cpu_run_o, sysclk_en_o, osc_en_o, pin_hold_o, pin_cond_a_o, pin_cond_b_o;
   wire warmup_busy_o, wake_o, wake_take_int_o;
   wire [8:0] periph_clk_en_o;
   wire [2:0] state_o;
   integer err_count, checks, i, n;
   // short warm-ups keep the run brief
   shc_standby_ctrl #(.WUP_CYC0(3), .WUP_CYC1(5), .WUP_CYC2(16), .WUP_CYC3(32)) dut (.*);
   shc_core_model u_core (.clk_i(clk_i), .nrst_i(nrst_i), .halt_cmd_i(hcmd), .cpu_run_i(cpu_run_o), .halt_req_o(halt_req_i));
   function integer wup(input integer s);
      wup = (s == 3) ? 32 : (s == 2) ? 16 : (s == 1) ? 5 : 3;
   endfunction
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task tick;
      begin
         @(posedge clk_i);
         #1;
      end
   endtask
   // mode and select held until the controller has taken the pulse
   task halt(input [1:0] m, input [1:0] s);
      begin
         halt_mode_field_i = m;
         warmup_select_field_i = s;
         hcmd = 1'b1;
         tick;
         tick;
         hcmd = 1'b0;
      end
   endtask
   task wake(input [3:0] e, input q, input m);
      begin
         ext_int_i = e;
         int_req_i = q;
         nmi_i = m;
         tick;
         ext_int_i = 4'h0;
         int_req_i = 1'b0;
         nmi_i = 1'b0;
      end
   endtask
   task results;
      begin
         if (err_count == 0 && checks > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   // free-running clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // watchdog, far beyond the 93 cycles needed
   initial begin
      #20000;
      err_count = err_count + 1;
      results;
   end
   // main sequence
   initial begin
      {err_count, checks, nrst_i, hcmd, int_req_i, nmi_i, drive_sel_i, drive_en_i} = 0;
      {halt_mode_field_i, warmup_select_field_i, int_level_i, ext_int_i} = 0;
      interrupt_mask_level_i = 3'h3;
      idle_run_en_i = 9'h0a5;
      tick;
      tick;
      nrst_i = 1'b1;
      chk({state_o, cpu_run_o, sysclk_en_o, osc_en_o, periph_clk_en_o}, {3'h0, 3'h7, 9'h1ff});
      for (i = 0; i < 2; i = i + 1) begin
         halt(i ? 2'h0 : 2'h3, 2'h0);
         chk({state_o, cpu_run_o, pin_hold_o, periph_clk_en_o}, {3'h1, 2'h1, 9'h0a5});
         int_level_i = 3'h2;
         wake(4'h0, 1'b1, 1'b0);
         chk(state_o, 3'h1);
         int_level_i = 3'h5;
         wake(4'h0, !i[0], i[0]);
         chk({wake_o, wake_take_int_o, state_o}, {2'h3, 3'h0});
      end
      for (i = 0; i < 4; i = i + 1) begin
         {drive_en_i, drive_sel_i} = i[1:0];
         halt(2'h2, 2'h0);
         chk({state_o, osc_en_o, sysclk_en_o, periph_clk_en_o, pin_cond_a_o}, {3'h2, 2'h2, 9'h000, i == 1});
         wake(4'h1 << i, 1'b0, 1'b0);
         chk({wake_o, wake_take_int_o, state_o, cpu_run_o}, {2'h2, 3'h0, 1'b1});
      end
      for (i = 0; i < 4; i = i + 1) begin
         {drive_en_i, drive_sel_i} = i[1:0];
         halt(2'h1, i[1:0]);
         chk({state_o, osc_en_o, sysclk_en_o, pin_cond_a_o}, {3'h3, 2'h0, i < 2});
         wake(4'h0, 1'b0, 1'b1);
         n = 0;
         while (wake_o !== 1'b1 && n < 100) begin
            if (n == 1) chk({warmup_busy_o, osc_en_o, sysclk_en_o}, 3'h6);
            tick;
            n = n + 1;
         end
         chk(n, wup(i));
      end
      halt(2'h1, 2'h3);
      nrst_i = 1'b0;
      tick;
      nrst_i = 1'b1;
      chk({state_o, cpu_run_o, osc_en_o, wake_o}, 6'h06);
      results;
   end
endmodule // tb
bind shc_standby_ctrl shc_props #(.N_PERIPH(N_PERIPH), .WUP_CYC0(WUP_CYC0), .WUP_CYC1(WUP_CYC1),
   .WUP_CYC2(WUP_CYC2), .WUP_CYC3(WUP_CYC3)) u_props (.*);
